// [src/cfg_mem_image.sv]
`timescale 1ns/100ps
module cfg_mem_image
    import crc_check_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Configuration-time write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_data,
    // Background read port
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data
);
    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read keeps the scan path to one cycle of latency
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : cfg_mem_image

// [src/config_memory_crc_checker.sv]
`timescale 1ns/100ps
module config_memory_crc_checker
    import crc_check_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Configuration stage
    input wire logic check_enable,
    input wire logic [DIV_EXP_W-1:0] div_exponent,
    input wire logic cfg_wr_en,
    input wire logic [ADDR_W-1:0] cfg_wr_addr,
    input wire logic [WORD_W-1:0] cfg_wr_data,
    input wire logic [CRC_W-1:0] cfg_reference,
    input wire logic cfg_done,
    // Boundary-scan access to the reference register
    input wire scan_ctrl_t scan_ctrl,
    output logic scan_out,
    // User-side readout
    input wire logic user_clk,
    input wire user_ctrl_t user_ctrl,
    output logic user_serial_out,
    // Integrity fault pin
    output logic fault_out,
    output logic fault_out_oe
);
    // ========================================
    // Pin input synchronisers
    logic [1:0] done_sync_q;
    logic [1:0] uclk_sync_q;
    logic [1:0] snl_sync_q;
    logic [1:0] lsrc_sync_q;
    logic [1:0] sa_sync_q;
    logic [1:0] ss_sync_q;
    logic [1:0] su_sync_q;
    logic [1:0] si_sync_q;
    logic [1:0] en_sync_q;
    // Straps are static, so the exponent bits may cross side by side
    logic [DIV_EXP_W-1:0] exp_sync0_q;
    logic [DIV_EXP_W-1:0] exp_sync1_q;
    logic [1:0] settle_q;
    logic uclk_prev_q;
    logic su_prev_q;
    logic ss_prev_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            done_sync_q <= '0;
            uclk_sync_q <= '0;
            snl_sync_q <= '0;
            lsrc_sync_q <= '0;
            sa_sync_q <= '0;
            ss_sync_q <= '0;
            su_sync_q <= '0;
            si_sync_q <= '0;
            en_sync_q <= '0;
            exp_sync0_q <= '0;
            exp_sync1_q <= '0;
            settle_q <= '0;
            uclk_prev_q <= 1'b0;
            su_prev_q <= 1'b0;
            ss_prev_q <= 1'b0;
        end else begin
            done_sync_q <= {done_sync_q[0], cfg_done};
            uclk_sync_q <= {uclk_sync_q[0], user_clk};
            snl_sync_q <= {snl_sync_q[0], user_ctrl.shift_not_load};
            lsrc_sync_q <= {lsrc_sync_q[0], user_ctrl.load_source_result};
            sa_sync_q <= {sa_sync_q[0], scan_ctrl.scan_active};
            ss_sync_q <= {ss_sync_q[0], scan_ctrl.scan_shift};
            su_sync_q <= {su_sync_q[0], scan_ctrl.scan_update};
            si_sync_q <= {si_sync_q[0], scan_ctrl.scan_in};
            en_sync_q <= {en_sync_q[0], check_enable};
            exp_sync0_q <= div_exponent;
            exp_sync1_q <= exp_sync0_q;
            settle_q <= {settle_q[0], 1'b1};
            uclk_prev_q <= uclk_sync_q[1];
            su_prev_q <= su_sync_q[1];
            ss_prev_q <= ss_sync_q[1];
        end
    end

    logic uclk_rise;
    logic scan_shift_pulse;
    logic scan_update_pulse;
    assign uclk_rise = uclk_sync_q[1] & ~uclk_prev_q;
    assign scan_shift_pulse = sa_sync_q[1] & ss_sync_q[1] & ~ss_prev_q;
    assign scan_update_pulse = sa_sync_q[1] & su_sync_q[1] & ~su_prev_q;

    // ========================================
    // Straps caught after reset release
    logic enable_q;
    logic [DIV_EXP_W-1:0] exp_q;
    logic strap_taken_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            enable_q <= 1'b0;
            exp_q <= DIV_EXP_RESET;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q && settle_q[1]) begin
            // Wait until the strap synchronisers hold pin values, not reset zeros
            strap_taken_q <= 1'b1;
            enable_q <= en_sync_q[1];
            // Out-of-range exponents clamp to the slowest legal rate
            exp_q <= (exp_sync1_q > DIV_EXP_MAX) ? DIV_EXP_MAX : exp_sync1_q;
        end
    end

    // ========================================
    // Check-clock divider, 1/2**n of the 80 MHz oscillator rate
    logic [7:0] div_cnt_q;
    logic [7:0] div_limit;
    logic tick;
    assign div_limit = 8'((9'h001 << exp_q) - 9'h001);
    assign tick = (div_cnt_q == div_limit);

    always_ff @(posedge sys_clk) begin
        if (!reset_n || tick) begin
            div_cnt_q <= DIV_CNT_ZERO;
        end else begin
            div_cnt_q <= div_cnt_q + DIV_CNT_ONE;
        end
    end

    // ========================================
    // Reference store and its scan chain
    logic [CRC_W-1:0] ref_q;
    logic [CRC_W-1:0] scan_chain_q;
    logic ref_loaded_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ref_q <= REF_RESET;
            ref_loaded_q <= 1'b0;
        end else if (done_sync_q[1] && !ref_loaded_q) begin
            ref_q <= cfg_reference;
            ref_loaded_q <= 1'b1;
        end else if (scan_update_pulse) begin
            // Checker keeps running; the new value counts from the next compare
            ref_q <= scan_chain_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scan_chain_q <= REF_RESET;
        end else if (!sa_sync_q[1]) begin
            scan_chain_q <= ref_q;
        end else if (scan_shift_pulse) begin
            scan_chain_q <= {si_sync_q[1], scan_chain_q[CRC_W-1:1]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scan_out <= 1'b0;
        end else begin
            scan_out <= scan_chain_q[0];
        end
    end

    // ========================================
    // Background scan of configuration memory
    chk_state_t state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [CRC_W-1:0] crc_q;
    logic [CRC_W-1:0] result_q;
    logic [WORD_W-1:0] mem_word;
    logic [CRC_W-1:0] crc_next;
    logic [ADDR_W-1:0] addr_d;

    cfg_mem_image u_mem (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wr_en(cfg_wr_en && !ref_loaded_q),
        .wr_addr(cfg_wr_addr),
        .wr_data(cfg_wr_data),
        .rd_addr(addr_d),
        .rd_data(mem_word)
    );

    crc32_word u_crc (
        .crc_in(crc_q),
        .data_in(mem_word),
        .crc_out(crc_next)
    );

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else if (tick) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (enable_q && ref_loaded_q) begin
                        state_q <= ST_SEED;
                    end
                end
                ST_SEED: begin
                    state_q <= ST_SCAN;
                end
                ST_SCAN: begin
                    if (addr_q == LAST_ADDR) begin
                        state_q <= ST_CMP;
                    end
                end
                ST_CMP: begin
                    state_q <= ST_SEED;
                end
            endcase
        end
    end

    // ========================================
    // Scan address
    // The memory reads at the next address, so its word always belongs to
    // addr_q whatever the divider; one tick behind would be a word late at 1:1
    always_comb begin
        addr_d = addr_q;
        if (tick) begin
            if (state_q == ST_SEED) begin
                addr_d = '0;
            end else if (state_q == ST_SCAN && addr_q != LAST_ADDR) begin
                addr_d = addr_q + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    // Each scan tick folds in the word held for addr_q
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            crc_q <= CRC_SEED;
        end else if (tick) begin
            if (state_q == ST_SEED) begin
                crc_q <= CRC_SEED;
            end else if (state_q == ST_SCAN) begin
                crc_q <= crc_next;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            result_q <= RESULT_RESET;
        end else if (tick && state_q == ST_CMP) begin
            // Each pass overwrites the last; zero means the image matches
            result_q <= crc_q ^ ref_q;
        end
    end

    // ========================================
    // Fault pin, present only when checking is enabled
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            fault_out <= 1'b0;
            fault_out_oe <= 1'b0;
        end else begin
            fault_out <= enable_q && (result_q != RESULT_RESET);
            fault_out_oe <= enable_q;
        end
    end

    // ========================================
    // User-side shift register; advisory only, the fault pin is the trusted flag
    logic [CRC_W-1:0] user_sr_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            user_sr_q <= '0;
        end else if (uclk_rise) begin
            if (!snl_sync_q[1]) begin
                user_sr_q <= lsrc_sync_q[1] ? result_q : ref_q;
            end else begin
                user_sr_q <= {user_sr_q[CRC_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            user_serial_out <= 1'b0;
        end else begin
            user_serial_out <= user_sr_q[CRC_W-1];
        end
    end
endmodule : config_memory_crc_checker

// [src/crc32_word.sv]
`timescale 1ns/100ps
module crc32_word
    import crc_check_pkg::*;
(
    // Running value and word
    input wire logic [CRC_W-1:0] crc_in,
    input wire logic [WORD_W-1:0] data_in,
    output logic [CRC_W-1:0] crc_out
);
    // ========================================
    // One serial step per data bit, unrolled
    logic [CRC_W-1:0] stage [0:WORD_W];

    assign stage[0] = crc_in;
    for (genvar i = 0; i < WORD_W; i++) begin : g_bit
        logic fb;
        assign fb = stage[i][CRC_W-1] ^ data_in[WORD_W-1-i];
        assign stage[i+1] = {stage[i][CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    assign crc_out = stage[WORD_W];
endmodule : crc32_word

// [src/crc_check_pkg.sv]
package crc_check_pkg;
    // ========================================
    // Widths and encodings
    localparam int CRC_W = 32;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
    localparam int WORD_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [7:0] LAST_ADDR = 8'hFF;
    localparam int DIV_EXP_W = 4;
    localparam logic [3:0] DIV_EXP_MAX = 4'h8;
    localparam logic [3:0] DIV_EXP_RESET = 4'h0;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    localparam logic [31:0] REF_RESET = 32'h00000000;
    localparam logic [7:0] DIV_CNT_ONE = 8'h01;
    localparam logic [7:0] DIV_CNT_ZERO = 8'h00;
    // ========================================
    // Error detection clock limits, in kHz
    localparam int OSC_KHZ = 80000;
    localparam int FMAX_KHZ = 80000;
    localparam int FMIN_KHZ = 312;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SEED = 4'b0010,
        ST_SCAN = 4'b0100,
        ST_CMP = 4'b1000
    } chk_state_t;

    typedef struct packed {
        logic shift_not_load;
        logic load_source_result;
    } user_ctrl_t;

    typedef struct packed {
        logic scan_active;
        logic scan_shift;
        logic scan_update;
        logic scan_in;
    } scan_ctrl_t;
endpackage : crc_check_pkg

// [verif/config_memory_crc_checker_tb.sv]
`timescale 1ns/100ps
module config_memory_crc_checker_tb
    import crc_check_pkg::*;
;
    typedef struct packed {
        logic [CRC_W-1:0] mask;
        logic fault;
    } row_t;
    // Injected error mask and the fault it gives
    localparam row_t ROWS [4] = '{'{32'h00000000, 1'b0}, '{32'h00000001, 1'b1},
        '{32'h80000000, 1'b1}, '{32'h00000000, 1'b0}};
    logic sys_clk;
    logic reset_n = 1'b0;
    logic check_enable = 1'b1;
    logic [DIV_EXP_W-1:0] div_exponent = 4'h0;
    logic cfg_wr_en = 1'b0;
    logic [ADDR_W-1:0] cfg_wr_addr = 8'h00;
    logic [WORD_W-1:0] cfg_wr_data = 32'h00000000;
    logic [CRC_W-1:0] cfg_reference = 32'h00000000;
    logic [CRC_W-1:0] good;
    logic cfg_done = 1'b0;
    scan_ctrl_t scan_ctrl = '0;
    user_ctrl_t user_ctrl;
    logic user_clk, scan_out, user_serial_out, fault_out, fault_out_oe, fault_seen;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    config_memory_crc_checker u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .check_enable(check_enable), .div_exponent(div_exponent), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .cfg_reference(cfg_reference),
        .cfg_done(cfg_done), .scan_ctrl(scan_ctrl), .scan_out(scan_out), .user_clk(user_clk),
        .user_ctrl(user_ctrl), .user_serial_out(user_serial_out), .fault_out(fault_out),
        .fault_out_oe(fault_out_oe));
    user_readout_model u_user (.sys_clk(sys_clk), .user_clk(user_clk), .user_ctrl(user_ctrl),
        .user_serial_out(user_serial_out), .fault_out(fault_out), .fault_seen(fault_seen));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ========================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    function automatic logic [CRC_W-1:0] crc_image();
        logic [CRC_W-1:0] c;
        logic [WORD_W-1:0] w;
        c = CRC_SEED;
        for (int a = 0; a < 256; a++) begin
            w = {4{a[7:0]}};
            for (int b = WORD_W - 1; b >= 0; b--) begin
                c = {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ w[b]) ? CRC_POLY : 32'h00000000);
            end
        end
        return c;
    endfunction : crc_image
    // Reset, straps, whole image, then end of configuration
    task automatic boot(input logic en, input logic [3:0] n, input logic [CRC_W-1:0] ref_val);
        reset_n = 1'b0;
        cfg_done = 1'b0;
        check_enable = en;
        div_exponent = n;
        step(4);
        reset_n = 1'b1;
        step(1);
        for (int a = 0; a < 256; a++) begin
            cfg_wr_en = 1'b1;
            cfg_wr_addr = a[7:0];
            cfg_wr_data = {4{a[7:0]}};
            step(1);
        end
        cfg_wr_en = 1'b0;
        cfg_reference = ref_val;
        cfg_done = 1'b1;
        // Let the reference load land before any scan access
        step(6);
    endtask : boot
    // Chain shifts LSB out, so the old reference appears while the new one goes in
    task automatic scan_word(input logic [CRC_W-1:0] nw, input logic [CRC_W-1:0] old);
        logic [CRC_W-1:0] seen;
        scan_ctrl.scan_active = 1'b1;
        step(6);
        for (int i = 0; i < CRC_W; i++) begin
            seen[i] = scan_out;
            scan_ctrl.scan_in = nw[i];
            scan_ctrl.scan_shift = 1'b1;
            step(6);
            scan_ctrl.scan_shift = 1'b0;
            step(6);
        end
        scan_ctrl.scan_update = 1'b1;
        step(6);
        scan_ctrl = '0;
        step(6);
        check("scan_out", old, seen);
    endtask : scan_word
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // ========================================
    // Main sequence
    initial begin
        logic [CRC_W-1:0] w;
        logic [CRC_W-1:0] prev;
        good = crc_image();
        boot(1'b1, 4'h0, good);
        prev = good;
        for (int r = 0; r < 4; r++) begin
            scan_word(good ^ ROWS[r].mask, prev);
            prev = good ^ ROWS[r].mask;
            step(600);
            check("fault", {31'h0, ROWS[r].fault}, {31'h0, fault_seen});
            u_user.read_word(1'b1, w);
            check("result", ROWS[r].mask, w);
            u_user.read_word(1'b0, w);
            check("reference", prev, w);
        end
        // Image writes after the load must be ignored
        cfg_wr_en = 1'b1;
        cfg_wr_data = 32'h5A5A5A5A;
        step(1);
        cfg_wr_en = 1'b0;
        step(600);
        check("late write", 32'h0, {31'h0, fault_out});
        boot(1'b0, 4'h0, ~good);
        step(600);
        check("off enable", 32'h0, {31'h0, fault_out_oe});
        check("off fault", 32'h0, {31'h0, fault_out});
        // Divide by two doubles the pass length
        boot(1'b1, 4'h1, ~good);
        step(450);
        check("slow early", 32'h0, {31'h0, fault_out});
        step(200);
        check("slow done", 32'h1, {31'h0, fault_out});
        check("slow enable", 32'h1, {31'h0, fault_out_oe});
        close_out();
    end
endmodule : config_memory_crc_checker_tb

// [verif/crc_checker_chk.sv]
`timescale 1ns/100ps
module crc_checker_chk
    import crc_check_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Watched ports
    input wire logic cfg_done,
    input wire scan_ctrl_t scan_ctrl,
    input wire logic scan_out,
    input wire logic user_clk,
    input wire logic user_serial_out,
    input wire logic fault_out,
    input wire logic fault_out_oe
);
    logic [8:0] gap_q;
    logic [3:0] sq_q;
    logic [3:0] uq_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ========================================
    // Cycles since each cause last moved
    always_ff @(posedge sys_clk) begin
        gap_q <= (!reset_n || $changed(fault_out)) ? 9'h000 : gap_q + {8'h00, gap_q != 9'h1FF};
        sq_q <= (!reset_n || $changed(scan_ctrl) || $changed(cfg_done)) ? 4'h0
            : sq_q + {3'h0, sq_q != 4'hF};
        uq_q <= (!reset_n || $changed(user_clk)) ? 4'h0 : uq_q + {3'h0, uq_q != 4'hF};
    end
    // ========================================
    // Properties
    a_reset_clears: assert property (disable iff (1'b0)
        !reset_n |=> !fault_out && !fault_out_oe && !scan_out && !user_serial_out)
        else $error("outputs not cleared");
    a_fault_gated: assert property (fault_out |-> fault_out_oe)
        else $error("fault while disabled");
    a_enable_steady: assert property ($past(reset_n, 5) |-> $stable(fault_out_oe))
        else $error("fault enable moved");
    a_fault_holds: assert property ($changed(fault_out) |=> $stable(fault_out) [*8])
        else $error("fault moved within a pass");
    a_pass_spacing: assert property ($changed(fault_out) |-> gap_q >= 9'h0FF)
        else $error("passes too close");
    a_no_early_fault: assert property (!$past(cfg_done, 4) |-> !fault_out)
        else $error("fault before user mode");
    a_scan_quiet: assert property (sq_q >= 4'h8 && !scan_ctrl.scan_active
        |-> $stable(scan_out))
        else $error("scan output moved idle");
    a_user_quiet: assert property (uq_q >= 4'h8 |-> $stable(user_serial_out))
        else $error("serial output moved idle");
endmodule : crc_checker_chk

bind config_memory_crc_checker crc_checker_chk u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .cfg_done(cfg_done), .scan_ctrl(scan_ctrl),
    .scan_out(scan_out), .user_clk(user_clk), .user_serial_out(user_serial_out),
    .fault_out(fault_out), .fault_out_oe(fault_out_oe)
);

// [verif/user_readout_model.sv]
`timescale 1ns/100ps
module user_readout_model
    import crc_check_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Readout port
    output logic user_clk,
    output user_ctrl_t user_ctrl,
    input wire logic user_serial_out,
    // Fault pin
    input wire logic fault_out,
    output logic fault_seen
);
    // Fabric may take the same upset, so only the pin is trusted
    assign fault_seen = fault_out;
    initial begin
        user_clk = 1'b0;
        user_ctrl = '0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // First edge loads, the rest shift; slow edges suit the synchroniser
    task automatic read_word(input logic src, output logic [CRC_W-1:0] w);
        user_ctrl = '{shift_not_load: 1'b0, load_source_result: src};
        tick(1);
        for (int i = CRC_W - 1; i >= 0; i--) begin
            user_clk = 1'b1;
            tick(6);
            user_clk = 1'b0;
            tick(6);
            w[i] = user_serial_out;
            user_ctrl.shift_not_load = 1'b1;
        end
    endtask : read_word
endmodule : user_readout_model
